// file: rtl/chan_mode_ctrl.sv
`timescale 1ns/100ps
module chan_mode_ctrl
  import chan_mode_pkg::*;
#(
  parameter int unit_cycles = timeout_unit_cycles,
  parameter int half_cycles = recovery_half_cycles,
  parameter int sda_stuck_cycles = 4 * recovery_half_cycles
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_oe,
  output logic aux_data_out,
  output logic aux_clock_out,
  input wire logic sequence_start_request,
  input wire logic chan_busy,
  output logic start_accept,
  output logic abort,
  output logic [7:0] scl_low_count,
  output logic [7:0] scl_high_count,
  output logic [3:0] scale_factor,
  output logic [1:0] speed_mode_select,
  output logic [7:0] channel_status,
  output logic int_n
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] scale_of(input logic [1:0] m);
    case (m)
      mode_std: scale_of = 4'h8;
      mode_fast: scale_of = 4'h4;
      default: scale_of = 4'h1;
    endcase
  endfunction : scale_of

  // nominal counts per mode; host may override via its own rate registers
  function automatic timing_t timing_of(input logic [1:0] m);
    timing_t t;
    t.scale_factor = scale_of(m);
    case (m)
      mode_std: begin
        t.scl_low_count = 8'h74;
        t.scl_high_count = 8'h4f;
      end
      mode_fast: begin
        t.scl_low_count = 8'h3a;
        t.scl_high_count = 8'h27;
      end
      default: begin
        t.scl_low_count = 8'h5a;
        t.scl_high_count = 8'h3f;
      end
    endcase
    timing_of = t;
  endfunction : timing_of

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  logic scl_s;
  logic sda_s;

  pin_sync u_scl_sync (
    .clk(clk),
    .rst(rst),
    .pin(scl_i),
    .level(scl_s)
  );

  pin_sync u_sda_sync (
    .clk(clk),
    .rst(rst),
    .pin(sda_i),
    .level(sda_s)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum {st_idle, st_rec_low, st_rec_high} rec_state_t;

  rec_state_t rec_q, rec_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] tout_q, tout_d;
  logic [1:0] err_q, err_d;
  logic [3:0] pulse_q, pulse_d;
  logic [15:0] half_q, half_d;
  logic [6:0] units_q, units_d;
  logic [15:0] unit_cnt_q, unit_cnt_d;
  logic [15:0] sda_cnt_q, sda_cnt_d;
  logic scl_prev_q, scl_prev_d;
  logic [7:0] rdata_q, rdata_d;
  pin_drive_t pins_q, pins_d;
  timing_t timing_q, timing_d;
  logic start_q, start_d;
  logic abort_q, abort_d;
  logic int_n_q, int_n_d;

  logic channel_enable;
  logic scl_fall;
  logic tout_hit;
  logic sda_stuck;
  logic rec_go;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    channel_enable = mode_q[channel_enable_pos];
    scl_fall = scl_prev_q & ~scl_s;
    mode_d = mode_q;
    tout_d = tout_q;
    err_d = err_q;
    rec_d = rec_q;
    pulse_d = pulse_q;
    half_d = half_q;
    units_d = units_q;
    unit_cnt_d = unit_cnt_q;
    sda_cnt_d = sda_cnt_q;
    scl_prev_d = scl_s;
    rdata_d = rdata_q;
    abort_d = 1'b0;

    // register writes; reserved bits masked to zero
    if (wr_en && addr == mode_reg_addr) begin
      mode_d = wdata & mode_rw_mask;
    end
    if (wr_en && addr == timeout_reg_addr) begin
      tout_d = wdata;
    end

    // sda stuck low while scl high and no recovery running
    if (!sda_s && scl_s && rec_q == st_idle && channel_enable) begin
      if (sda_cnt_q != 16'(sda_stuck_cycles)) begin
        sda_cnt_d = sda_cnt_q + 16'h1;
      end
    end else begin
      sda_cnt_d = 16'h0;
    end
    sda_stuck = (sda_cnt_q == 16'(sda_stuck_cycles - 1));

    // scl low time-out: reload on falling edge, count while low
    tout_hit = 1'b0;
    if (scl_fall || scl_s || !tout_q[te_pos] || !channel_enable) begin
      units_d = tout_q[6:0];
      unit_cnt_d = 16'h0;
    end else if (unit_cnt_q == 16'(unit_cycles - 1)) begin
      unit_cnt_d = 16'h0;
      if (units_q == 7'h0) begin
        tout_hit = 1'b1;
        units_d = tout_q[6:0];
      end else begin
        units_d = units_q - 7'h1;
      end
    end else begin
      unit_cnt_d = unit_cnt_q + 16'h1;
    end

    // error flags: set wins over the read clear
    if (rd_en && addr == status_reg_addr) begin
      err_d = 2'h0;
    end
    if (tout_hit && tout_q[te_pos]) begin
      err_d[cle_pos] = 1'b1;
      abort_d = 1'b1;
    end
    rec_go = 1'b0;
    if (sda_stuck) begin
      if (mode_q[ar_pos]) begin
        rec_go = 1'b1;
      end else begin
        err_d[dae_pos] = 1'b1;
        abort_d = 1'b1;
      end
    end

    // recovery pulse train
    case (rec_q)
      st_idle: begin
        if ((mode_q[br_pos] || rec_go) && channel_enable) begin
          rec_d = st_rec_low;
          pulse_d = 4'h0;
          half_d = 16'h0;
        end
      end
      st_rec_low: begin
        if (half_q == 16'(half_cycles - 1)) begin
          half_d = 16'h0;
          rec_d = st_rec_high;
        end else begin
          half_d = half_q + 16'h1;
        end
      end
      st_rec_high: begin
        // wait for released scl so a stretching slave is honoured
        if (!scl_s) begin
          half_d = 16'h0;
        end else if (half_q == 16'(half_cycles - 1)) begin
          half_d = 16'h0;
          if (pulse_q == 4'(recovery_pulses - 1)) begin
            rec_d = st_idle;
            mode_d[br_pos] = 1'b0;
          end else begin
            pulse_d = pulse_q + 4'h1;
            rec_d = st_rec_low;
          end
        end else begin
          half_d = half_q + 16'h1;
        end
      end
      default: rec_d = st_idle;
    endcase

    // pins: disabled channel floats the bus and parks aux lines high
    pins_d.aux_data_out = 1'b1;
    pins_d.aux_clock_out = channel_enable ? (rec_q != st_rec_low) : 1'b1;
    pins_d.scl_o = 1'b0;
    pins_d.scl_oe = channel_enable && (rec_q == st_rec_low) && !abort_d;
    pins_d.sda_oe = 1'b0;

    // a start is passed on only when enabled and the bus is free
    start_d = sequence_start_request && channel_enable && rec_q == st_idle && !chan_busy;

    timing_d = timing_of(mode_q[1:0]);

    int_n_d = ~(|err_d);

    if (rd_en) begin
      case (addr)
        mode_reg_addr: rdata_d = mode_q;
        timeout_reg_addr: rdata_d = tout_q;
        status_reg_addr: rdata_d = {6'h0, err_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= mode_reset;
      tout_q <= timeout_reset;
      err_q <= 2'h0;
      rec_q <= st_idle;
      pulse_q <= 4'h0;
      half_q <= 16'h0;
      units_q <= 7'h0;
      unit_cnt_q <= 16'h0;
      sda_cnt_q <= 16'h0;
      scl_prev_q <= 1'b1;
      rdata_q <= 8'h00;
      pins_q <= '{scl_o: 1'b0, scl_oe: 1'b0, sda_oe: 1'b0,
                  aux_data_out: 1'b1, aux_clock_out: 1'b1};
      timing_q <= '{scl_low_count: 8'h5a, scl_high_count: 8'h3f, scale_factor: 4'h1};
      start_q <= 1'b0;
      abort_q <= 1'b0;
      int_n_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      tout_q <= tout_d;
      err_q <= err_d;
      rec_q <= rec_d;
      pulse_q <= pulse_d;
      half_q <= half_d;
      units_q <= units_d;
      unit_cnt_q <= unit_cnt_d;
      sda_cnt_q <= sda_cnt_d;
      scl_prev_q <= scl_prev_d;
      rdata_q <= rdata_d;
      pins_q <= pins_d;
      timing_q <= timing_d;
      start_q <= start_d;
      abort_q <= abort_d;
      int_n_q <= int_n_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign rdata = rdata_q;
  assign scl_o = pins_q.scl_o;
  assign scl_oe = pins_q.scl_oe;
  assign sda_oe = pins_q.sda_oe;
  assign aux_data_out = pins_q.aux_data_out;
  assign aux_clock_out = pins_q.aux_clock_out;
  assign start_accept = start_q;
  assign abort = abort_q;
  assign scl_low_count = timing_q.scl_low_count;
  assign scl_high_count = timing_q.scl_high_count;
  assign scale_factor = timing_q.scale_factor;
  assign speed_mode_select = mode_q[1:0];
  assign channel_status = {6'h0, err_q};
  assign int_n = int_n_q;

endmodule : chan_mode_ctrl

// file: shared/chan_mode_pkg.sv
package chan_mode_pkg;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] mode_reg_addr = 8'hcd;
  localparam logic [7:0] timeout_reg_addr = 8'hce;
  localparam logic [7:0] status_reg_addr = 8'hc0;
  localparam int channel_enable_pos = 7;
  localparam int br_pos = 5;
  localparam int ar_pos = 4;
  localparam int te_pos = 7;
  localparam logic [7:0] mode_rw_mask = 8'hb3;
  localparam logic [7:0] mode_reset = 8'h92;
  localparam logic [7:0] timeout_reset = 8'h00;
  localparam int dae_pos = 0;
  localparam int cle_pos = 1;

  // ----------------------------------------------------------------
  // speed modes and timing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    mode_std = 2'h0,
    mode_fast = 2'h1,
    mode_fmp = 2'h2,
    mode_rsvd = 2'h3
  } speed_mode_t;

  localparam int clk_mhz = 50;
  localparam int timeout_unit_us = 200;
  localparam int timeout_unit_cycles = timeout_unit_us * clk_mhz;
  localparam int recovery_pulses = 9;
  localparam int recovery_half_cycles = 250;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_oe;
    logic aux_data_out;
    logic aux_clock_out;
  } pin_drive_t;

  typedef struct packed {
    logic [7:0] scl_low_count;
    logic [7:0] scl_high_count;
    logic [3:0] scale_factor;
  } timing_t;

endpackage : chan_mode_pkg

// file: rtl/pin_sync.sv
`timescale 1ns/100ps
module pin_sync
  import chan_mode_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);

  // ----------------------------------------------------------------
  // three-stage sampler, change accepted when stages two and three agree
  // ----------------------------------------------------------------
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic level_q;
  logic level_d;

  // shift in; first stage is only read by the second
  always_comb begin
    sh_d = {sh_q[1:0], pin};
    level_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : level_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sh_q <= 3'h7;
      level_q <= 1'b1;
    end else begin
      sh_q <= sh_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;

endmodule : pin_sync

// file: test/chan_mode_monitor.sv
`timescale 1ns/100ps
module chan_mode_monitor
  import chan_mode_pkg::*;
#(
  parameter int unit_cycles = timeout_unit_cycles,
  parameter int half_cycles = recovery_half_cycles
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic scl_i,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic aux_data_out,
  input wire logic aux_clock_out,
  input wire logic start_accept,
  input wire logic abort,
  input wire logic [7:0] scl_low_count,
  input wire logic [7:0] scl_high_count,
  input wire logic [3:0] scale_factor,
  input wire logic [1:0] speed_mode_select,
  input wire logic [7:0] channel_status,
  input wire logic int_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // shadows of host writes and line time counters
  // ----------------------------------------------------------------
  logic channel_enable_q, channel_enable_d, ar_q, ar_d, te_q, te_d;
  logic [6:0] to_q, to_d;
  int lo_q, lo_d, hi_q, hi_d, lim;
  logic mw, tw;
  assign mw = wr_en && addr == mode_reg_addr;
  assign tw = wr_en && addr == timeout_reg_addr;
  assign lim = (int'(to_q) + 1) * unit_cycles;
  // next values
  always_comb begin
    channel_enable_d = mw ? wdata[channel_enable_pos] : channel_enable_q;
    ar_d = mw ? wdata[ar_pos] : ar_q;
    te_d = tw ? wdata[te_pos] : te_q;
    to_d = tw ? wdata[6:0] : to_q;
    lo_d = scl_i ? 0 : lo_q + 1;
    hi_d = scl_oe ? hi_q + 1 : 0;
  end
  // registers, reset to the documented defaults
  always_ff @(posedge clk) begin
    if (rst) begin
      channel_enable_q <= 1'b1;
      ar_q <= 1'b1;
      te_q <= 1'b0;
      to_q <= 7'h00;
      lo_q <= 0;
      hi_q <= 0;
    end else begin
      channel_enable_q <= channel_enable_d;
      ar_q <= ar_d;
      te_q <= te_d;
      to_q <= to_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
    end
  end
  function automatic logic [21:0] timing(input logic [1:0] m);
    case (m)
      2'h0: return {m, 8'h74, 8'h4f, 4'h8};
      2'h1: return {m, 8'h3a, 8'h27, 4'h4};
      default: return {m, 8'h5a, 8'h3f, 4'h1};
    endcase
  endfunction : timing
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_br_write;
    mw && wdata[br_pos] && wdata[channel_enable_pos];
  endsequence
  property p_dis_float;
    (!channel_enable_q) [*3] |-> !scl_oe && !sda_oe && aux_data_out && aux_clock_out;
  endproperty
  property p_no_start;
    (!channel_enable_q) [*2] |-> !start_accept;
  endproperty
  property p_mode_out;
    mw |=> speed_mode_select == $past(wdata[1:0]);
  endproperty
  // counts lag the mode by a register, so wait for it to settle
  property p_scale;
    speed_mode_select != 2'h3 ##1 $stable(speed_mode_select) [*2]
      |-> {speed_mode_select, scl_low_count, scl_high_count, scale_factor}
        == timing(speed_mode_select);
  endproperty
  property p_int;
    $stable(channel_status) |-> int_n == (channel_status == 8'h00);
  endproperty
  property p_status_clr;
    rd_en && addr == status_reg_addr && !abort |=> channel_status == 8'h00 || abort;
  endproperty
  property p_br_start;
    s_br_write |-> ##[1:4] scl_oe;
  endproperty
  property p_half;
    $fell(scl_oe) |-> hi_q == half_cycles;
  endproperty
  // sync latency allows a few cycles past the exact period
  property p_timeout;
    $rose(channel_status[cle_pos]) |-> te_q && lo_q >= lim && lo_q <= lim + 8;
  endproperty
  property p_dae;
    $rose(channel_status[dae_pos]) |-> !ar_q;
  endproperty
  a_dis_float: assert property (p_dis_float) else $error("lines not released");
  a_no_start: assert property (p_no_start) else $error("start taken");
  a_mode_out: assert property (p_mode_out) else $error("mode select");
  a_scale: assert property (p_scale) else $error("timing set");
  a_int: assert property (p_int) else $error("interrupt level");
  a_status_clr: assert property (p_status_clr) else $error("status kept");
  a_br_start: assert property (p_br_start) else $error("no recovery");
  a_half: assert property (p_half) else $error("pulse width");
  a_timeout: assert property (p_timeout) else $error("time-out period");
  a_dae: assert property (p_dae) else $error("data error with auto");
endmodule : chan_mode_monitor

bind chan_mode_ctrl chan_mode_monitor #(
  .unit_cycles(unit_cycles),
  .half_cycles(half_cycles)
) mon (.clk, .rst, .addr, .wdata, .wr_en, .rd_en, .scl_i, .scl_oe, .sda_oe, .aux_data_out,
  .aux_clock_out, .start_accept, .abort, .scl_low_count, .scl_high_count, .scale_factor,
  .speed_mode_select, .channel_status, .int_n);

// file: test/bus_partner.sv
`timescale 1ns/100ps
// slaves on the open-drain pair; lines have pull-ups
module bus_partner (
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic hold_scl,
  input wire logic hold_sda,
  input wire logic run_clk,
  output logic scl,
  output logic sda
);
  logic ext = 1'b1;
  // foreign clock only inside a burst, idle high otherwise
  always #80 ext = run_clk ? !ext : 1'b1;
  // wired-and: any party pulling low wins
  // gated so the line parks high the moment a burst stops, not at the next tick
  assign scl = !(scl_oe || hold_scl) && (ext || !run_clk);
  assign sda = !(sda_oe || hold_sda);
endmodule : bus_partner

// file: test/tb.sv
`timescale 1ns/100ps
module tb;
  import chan_mode_pkg::*;
  logic clk, rst, wr_en, rd_en, req, busy, hold_scl, hold_sda, run_clk;
  logic scl, sda, scl_oe, sda_oe, aux_d, aux_c, acc, abort, int_n, oe_prev, ab_seen;
  logic acc_w, scl_o_w;
  logic [7:0] addr, wdata, rdata, low_c, high_c, status, d, v;
  logic [3:0] scale;
  logic [1:0] sel;
  int n_fail, check_count, seed, rises, i, to;
  chan_mode_ctrl #(.unit_cycles(20), .half_cycles(4), .sda_stuck_cycles(16)) dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .scl_i(scl), .sda_i(sda), .scl_o(scl_o_w), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .aux_data_out(aux_d), .aux_clock_out(aux_c), .sequence_start_request(req),
    .chan_busy(busy), .start_accept(acc_w), .abort(abort), .scl_low_count(low_c),
    .scl_high_count(high_c), .scale_factor(scale), .speed_mode_select(sel),
    .channel_status(status), .int_n(int_n));
  bus_partner far (.scl_oe(scl_oe), .sda_oe(sda_oe), .hold_scl(hold_scl),
    .hold_sda(hold_sda), .run_clk(run_clk), .scl(scl), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // recovery pulse and abort bookkeeping
  always @(posedge clk) begin
    oe_prev <= scl_oe;
    if (scl_oe && !oe_prev) rises++;
    if (abort) ab_seen <= 1'b1;
  end
  task automatic chk(input string name, input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] val);
    addr <= a;
    wdata <= val;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 q = rdata;
    @(posedge clk);
  endtask : rd
  // sample start acceptance over a few cycles
  task automatic probe();
    acc = 1'b0;
    repeat (4) begin
      @(posedge clk);
      #1 acc = acc | acc_w;
    end
    @(posedge clk);
  endtask : probe
  function automatic logic [21:0] timing(input logic [1:0] m);
    case (m)
      2'h0: return {m, 8'h74, 8'h4f, 4'h8};
      2'h1: return {m, 8'h3a, 8'h27, 4'h4};
      default: return {m, 8'h5a, 8'h3f, 4'h1};
    endcase
  endfunction : timing
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end
  initial begin
    seed = 76061;
    {wr_en, rd_en, req, busy, hold_scl, hold_sda, run_clk, ab_seen, oe_prev} = '0;
    addr = 8'h00;
    wdata = 8'h00;
    rises = 0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(mode_reg_addr, d); chk("mode", d, 8'h92);
    rd(timeout_reg_addr, d); chk("timeout", d, 8'h00);
    rd(8'h55, d); chk("unmapped", d, 8'h00);
    $display("reset test done");
    // std, fast and fmp speed modes (not mode_rsvd), reserved bits random
    for (i = 0; i < 3; i++) begin
      v = 8'h90 | 8'($random(seed) & 8'h4c) | 8'(i);
      wr(mode_reg_addr, v);
      rd(mode_reg_addr, d); chk("mode rd", d, v & 8'hb3);
      chk("timing", {sel, low_c, high_c, scale}, timing(2'(i)));
      chk("sel", sel, 8'(i));
    end
    $display("mode test done");
    wr(mode_reg_addr, 8'h12);
    req <= 1'b1;
    probe(); chk("refuse", acc, 1'b0);
    chk("float", {scl_o_w, scl_oe, sda_oe, aux_d, aux_c}, 5'h03);
    rd(mode_reg_addr, d); chk("dis rd", d, 8'h12);
    wr(mode_reg_addr, 8'h92);
    probe(); chk("accept", acc, 1'b1);
    busy <= 1'b1;
    probe(); chk("busy", acc, 1'b0);
    busy <= 1'b0;
    req <= 1'b0;
    $display("enable test done");
    rises = 0;
    wr(mode_reg_addr, 8'hb2);
    d = 8'hff;
    for (i = 0; i < 100 && d[br_pos]; i++) rd(mode_reg_addr, d);
    chk("br clear", d, 8'h92);
    chk("pulses", rises, 9);
    rises = 0;
    hold_sda <= 1'b1;
    for (i = 0; i < 300 && rises == 0; i++) @(posedge clk);
    hold_sda <= 1'b0;
    repeat (150) @(posedge clk);
    chk("auto", {rises[7:0], status}, {8'h09, 8'h00});
    wr(mode_reg_addr, 8'h82);
    rises = 0;
    hold_sda <= 1'b1;
    for (i = 0; i < 300 && !status[dae_pos]; i++) @(posedge clk);
    hold_sda <= 1'b0;
    repeat (3) @(posedge clk);
    chk("dae", {rises[7:0], status, ab_seen, int_n}, {8'h00, 8'h01, 2'b10});
    rd(status_reg_addr, d); chk("st rd", d, 8'h01);
    rd(status_reg_addr, d); chk("st clr", {d, int_n}, {8'h00, 1'b1});
    $display("recovery test done");
    wr(mode_reg_addr, 8'h92);
    to = $random(seed) & 3;
    wr(timeout_reg_addr, 8'h80 | 8'(to));
    run_clk <= 1'b1;
    repeat (200) @(posedge clk);
    run_clk <= 1'b0;
    chk("reload", status, 8'h00);
    ab_seen <= 1'b0;
    req <= 1'b1;
    hold_scl <= 1'b1;
    repeat ((to + 1) * 20 + 12) @(posedge clk);
    chk("stuck", {status, ab_seen, int_n}, {8'h02, 2'b10});
    hold_scl <= 1'b0;
    req <= 1'b0;
    rd(status_reg_addr, d); chk("cle rd", d, 8'h02);
    wr(timeout_reg_addr, 8'(to));
    hold_scl <= 1'b1;
    repeat (200) @(posedge clk);
    hold_scl <= 1'b0;
    chk("te off", status, 8'h00);
    $display("time-out test done");
    final_report();
  end
endmodule : tb
